// file: verilog/phy_led_pkg.sv
// Shared constants, types and helpers for the indicator and mode block
package phy_led_pkg;
  // Register offsets on the management port
  localparam logic [4:0] BASIC_CONTROL_IDX = 5'h00;
  localparam logic [4:0] PHY_STATUS_IDX = 5'h10;
  localparam logic [4:0] PHY_CONTROL_IDX = 5'h19;
  // Basic control fields
  localparam int BC_LOOPBACK = 14;
  localparam int BC_SPEED100 = 13;
  localparam int BC_AN_ENABLE = 12;
  localparam int BC_ISOLATE = 10;
  localparam int BC_FULL_DUPLEX = 8;
  localparam logic [15:0] BASIC_CONTROL_RST = 16'h3000;
  // Phy control fields
  localparam int PC_PRBS_LONG = 10;
  localparam int PC_SELF_TEST_RUN = 9;
  localparam int PC_SELF_TEST_PASS = 8;
  // Phy status fields
  localparam int ST_LINK = 0;
  localparam int ST_SPEED10 = 1;
  localparam int ST_FULL_DUPLEX = 2;
  localparam int ST_LOOPBACK = 3;
  // Strap bit of each shared indicator
  localparam int STRAP_DUPLEX = 0;
  localparam int STRAP_COL = 1;
  localparam int STRAP_LINK = 2;
  localparam int STRAP_TX = 3;
  localparam int STRAP_RX = 4;
  // Link pulse qualification and loss timing
  localparam logic [2:0] NLP_GOOD_COUNT = 3'h7;
  localparam int CLK_HZ = 50_000_000;
  localparam int LINK_LOSS_US = 50_000;
  localparam int LINK_LOSS_CYCLES = LINK_LOSS_US * (CLK_HZ / 1_000_000);
  // Pattern generator
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam logic [3:0] PRBS_LEN_SHORT = 4'h9;
  localparam logic [3:0] PRBS_LEN_LONG = 4'hF;
  // Self-test sequencing, gray along idle, sync, run
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_RUN = 2'b11
  } self_test_st_t;
  // Next pattern bit: x^15+x^14+1 or x^9+x^5+1
  function automatic logic prbs_next(input logic [14:0] s,
                                     input logic long_seq);
    prbs_next = long_seq ? (s[14] ^ s[13]) : (s[8] ^ s[4]);
  endfunction : prbs_next
endpackage : phy_led_pkg

// file: verilog/phy_led_duplex_isolate_self_test.sv
// Indicator, duplex, isolate, loopback and self-test logic of the phy
module phy_led_duplex_isolate_self_test
  import phy_led_pkg::*;
#(
  parameter int LOSS_CYCLES = LINK_LOSS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Management register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Straps, valid at reset release
  input wire logic [4:0] address_strap_inputs,
  input wire logic indicator_polarity_strap,
  // Negotiation result and line status
  input wire logic an_speed100,
  input wire logic an_full_duplex,
  input wire logic an_parallel_detect,
  input wire logic signal_detect,
  input wire logic link_pulse,
  input wire logic packet_good10,
  input wire logic rx_carrier,
  // Decoded receive nibbles from the line
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  input wire logic line_rx_er,
  // MII transmit side from the MAC
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  // MII receive side to the MAC
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  output logic mii_oe,
  // Transmit nibbles to the line coder
  output logic [3:0] line_txd,
  output logic line_tx_en,
  output logic line_tx_er,
  // Indicator pins and their enable
  output logic duplex_indicator_out,
  output logic rate_indicator_out,
  output logic link_indicator_out,
  output logic col_indicator_out,
  output logic rx_activity_indicator,
  output logic tx_activity_indicator,
  output logic indicator_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter check
  initial begin
    if (LOSS_CYCLES < 1) begin
      $error("LOSS_CYCLES must be at least one");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] bctl;    // Basic control contents
    logic [4:0] addr;     // Address field of phy control
    logic prbs_long;      // Pattern length select
    logic run;            // Self-test run bit
    logic pass;           // Self-test pass status
    logic err;            // Miscompare latch
    logic [4:0] strap;    // Address straps at reset
    logic pol;            // Indicator polarity strap
    logic strap_done;     // Straps captured
    logic link10;         // 10 Mb/s link state
    logic [2:0] nlp;      // Consecutive link pulses
    logic [31:0] loss;    // Link loss timer
    self_test_st_t bst;   // Self-test sequencer
    logic [14:0] gen;     // Generator shift register
    logic [14:0] hist;    // Checker history
    logic [3:0] fill;     // Checker history fill
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic crs;
    logic col;
    logic [3:0] ltxd;
    logic ltx_en;
    logic ltx_er;
    logic [5:0] led;      // Dup, rate, link, col, rx, tx
    logic [15:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Resolved mode, visible to the assertions as well
  logic an_en;
  logic speed100;
  logic full_dup;
  logic loop;
  logic iso;
  logic link;
  logic tx_act;
  logic rx_act;
  logic col_raw;
  logic ctl_wr;
  logic gen_bit;
  logic chk_bit;
  logic chk_vld;
  logic [3:0] need;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d = s_q;
    an_en = s_q.bctl[BC_AN_ENABLE];
    speed100 = an_en ? an_speed100 : s_q.bctl[BC_SPEED100];
    // Forced partners look half duplex, so parallel detect never says full
    full_dup = !an_parallel_detect &&
      (an_en ? an_full_duplex : s_q.bctl[BC_FULL_DUPLEX]);
    loop = s_q.bctl[BC_LOOPBACK];
    // Only the strapped address isolates, never a written one
    iso = s_q.bctl[BC_ISOLATE] ||
      (s_q.strap_done && s_q.strap == 5'h00);
    link = speed100 ? signal_detect : s_q.link10;
    // Transmit inputs are ignored while isolated
    tx_act = tx_en && !iso;
    rx_act = loop ? tx_act : rx_carrier;
    // Collision sensing is off in full duplex and in loopback
    col_raw = !full_dup && !loop && tx_act && rx_carrier;
    ctl_wr = reg_wr && reg_addr == PHY_CONTROL_IDX;
    need = s_q.prbs_long ? PRBS_LEN_LONG : PRBS_LEN_SHORT;
    gen_bit = prbs_next(s_q.gen, s_q.prbs_long);
    chk_bit = loop ? s_q.ltxd[0] : line_rxd[0];
    chk_vld = loop ? s_q.ltx_en : line_rx_dv;

    // Strap capture on the first edge after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.strap = address_strap_inputs;
      s_d.pol = indicator_polarity_strap;
      s_d.addr = address_strap_inputs;
    end

    // Register writes; every access works while isolated
    if (reg_wr) begin
      case (reg_addr)
        BASIC_CONTROL_IDX: begin
          s_d.bctl = reg_wdata;
        end
        PHY_CONTROL_IDX: begin
          s_d.addr = reg_wdata[4:0];
          s_d.prbs_long = reg_wdata[PC_PRBS_LONG];
          s_d.run = reg_wdata[PC_SELF_TEST_RUN];
        end
        default: begin
          // Other offsets ignore writes
        end
      endcase
    end

    // Read data, one cycle after the strobe
    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        BASIC_CONTROL_IDX: begin
          s_d.rdata = s_q.bctl;
        end
        PHY_STATUS_IDX: begin
          s_d.rdata[ST_LINK] = link;
          s_d.rdata[ST_SPEED10] = !speed100;
          s_d.rdata[ST_FULL_DUPLEX] = full_dup;
          s_d.rdata[ST_LOOPBACK] = loop;
        end
        PHY_CONTROL_IDX: begin
          s_d.rdata[4:0] = s_q.addr;
          s_d.rdata[PC_PRBS_LONG] = s_q.prbs_long;
          s_d.rdata[PC_SELF_TEST_RUN] = s_q.run;
          s_d.rdata[PC_SELF_TEST_PASS] = s_q.pass;
        end
        default: begin
          // Unmapped offsets read zero
        end
      endcase
    end

    // 10 Mb/s link: pulses restart the loss timer
    if (link_pulse || packet_good10) begin
      s_d.loss = 32'h0000_0000;
      if (packet_good10) begin
        s_d.link10 = 1'b1;
      end
      if (s_q.nlp != NLP_GOOD_COUNT) begin
        s_d.nlp = s_q.nlp + 3'h1;
      end
      if (link_pulse && s_q.nlp == NLP_GOOD_COUNT - 3'h1) begin
        s_d.link10 = 1'b1;
      end
    end else if (s_q.loss == 32'(LOSS_CYCLES - 1)) begin
      // Timer ran out: the only way the link falls
      s_d.link10 = 1'b0;
      s_d.nlp = 3'h0;
      s_d.loss = 32'h0000_0000;
    end else begin
      s_d.loss = s_q.loss + 32'h0000_0001;
    end

    // Self-test sequencer and checker
    if (ctl_wr) begin
      // Starting clears the old status; stopping leaves it readable
      s_d.bst = reg_wdata[PC_SELF_TEST_RUN] ? ST_SYNC : ST_IDLE;
      if (reg_wdata[PC_SELF_TEST_RUN]) begin
        s_d.pass = 1'b0;
        s_d.err = 1'b0;
        s_d.fill = 4'h0;
      end
    end
    case (s_q.bst)
      ST_IDLE: begin
        // Stopped: last status stays readable
      end
      ST_SYNC: begin
        if (chk_vld) begin
          s_d.hist = {s_q.hist[13:0], chk_bit};
          s_d.fill = s_q.fill + 4'h1;
          if (s_q.fill == need - 4'h1 && !ctl_wr) begin
            s_d.bst = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (chk_vld) begin
          s_d.hist = {s_q.hist[13:0], chk_bit};
          // A miscompare wins over a same-cycle clearing write
          if (chk_bit != prbs_next(s_q.hist, s_q.prbs_long)) begin
            s_d.err = 1'b1;
            s_d.pass = 1'b0;
          end else if (!s_q.err && !ctl_wr) begin
            s_d.pass = 1'b1;
          end
        end
      end
      default: begin
        s_d.bst = ST_IDLE;
      end
    endcase
    if (s_q.run) begin
      s_d.gen = {s_q.gen[13:0], gen_bit};
    end

    // Line transmit: pattern, or MAC data unless isolated
    if (s_q.run) begin
      s_d.ltxd = {3'h0, gen_bit};
      s_d.ltx_en = 1'b1;
      s_d.ltx_er = 1'b0;
    end else begin
      s_d.ltxd = iso ? 4'h0 : txd;
      s_d.ltx_en = tx_act;
      s_d.ltx_er = tx_er && !iso;
    end

    // MII receive side: loopback takes transmit data
    if (loop) begin
      s_d.rxd = iso ? 4'h0 : txd;
      s_d.rx_dv = tx_act;
      s_d.rx_er = tx_er && !iso;
    end else begin
      s_d.rxd = line_rxd;
      s_d.rx_dv = line_rx_dv;
      s_d.rx_er = line_rx_er;
    end
    s_d.crs = full_dup ? rx_act : (rx_act || tx_act);
    s_d.col = col_raw;

    // Indicators: strap bit high makes the pin active low; duplex also needs the polarity strap, rate has no strap
    s_d.led[5] = s_q.pol ? (full_dup ^ s_q.strap[STRAP_DUPLEX])
                         : full_dup;
    s_d.led[4] = speed100;
    s_d.led[3] = link ^ s_q.strap[STRAP_LINK];
    s_d.led[2] = (col_raw && !full_dup) ^ s_q.strap[STRAP_COL];
    s_d.led[1] = rx_act ^ s_q.strap[STRAP_RX];
    s_d.led[0] = tx_act ^ s_q.strap[STRAP_TX];
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.bctl <= BASIC_CONTROL_RST;
      s_q.gen <= PRBS_SEED;
      s_q.bst <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = s_q.rdata;
  assign rxd = s_q.rxd;
  assign rx_dv = s_q.rx_dv;
  assign rx_er = s_q.rx_er;
  assign crs = s_q.crs;
  assign col = s_q.col;
  // Also gates the MII clock drivers outside this block
  assign mii_oe = s_q.strap_done && !iso;
  // During 100 Mb/s loopback line_tx_en is held low; line_txd and line_tx_er still follow
  assign line_tx_en = s_q.ltx_en && !(loop && speed100);
  assign line_txd = s_q.ltxd;
  assign line_tx_er = s_q.ltx_er;
  assign duplex_indicator_out = s_q.led[5];
  assign rate_indicator_out = s_q.led[4];
  assign link_indicator_out = s_q.led[3];
  assign col_indicator_out = s_q.led[2];
  assign rx_activity_indicator = s_q.led[1];
  assign tx_activity_indicator = s_q.led[0];
  // Pins stay undriven until the straps are taken
  assign indicator_oe = s_q.strap_done;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  dup_led_pol_a: assert property (s_q.strap_done |=>
    duplex_indicator_out ==
    ($past(full_dup) ^ (s_q.pol & s_q.strap[STRAP_DUPLEX])))
    else $error("duplex indicator level wrong");
  rate_led_a: assert property (s_q.strap_done |=>
    rate_indicator_out == $past(speed100))
    else $error("rate indicator wrong");
  link_led_a: assert property (s_q.strap_done |=>
    link_indicator_out == ($past(link) ^ s_q.strap[STRAP_LINK]))
    else $error("link indicator level wrong");
  col_full_a: assert property (s_q.strap_done && full_dup |=>
    col_indicator_out == s_q.strap[STRAP_COL] && !col)
    else $error("collision shown in full duplex");
  crs_half_a: assert property (!full_dup && tx_act |=> crs)
    else $error("carrier sense missing on transmit");
  iso_float_a: assert property (s_q.strap_done |->
    mii_oe == !(s_q.bctl[BC_ISOLATE] || s_q.strap == 5'h00))
    else $error("MII driven while isolated");
  iso_line_a: assert property (iso && !s_q.run |=>
    !line_tx_en)
    else $error("packet sent while isolated");
  loop_sts_a: assert property (reg_rd && reg_addr == PHY_STATUS_IDX
    |=> reg_rdata[ST_LOOPBACK] == $past(loop))
    else $error("loopback status wrong");
  self_test_latch_a: assert property (s_q.err && !ctl_wr |=>
    !s_q.pass [*2])
    else $error("pass set after miscompare");
  link_drop_a: assert property ($past(s_q.link10) && !s_q.link10 |->
    !$past(link_pulse) && !$past(packet_good10) &&
    $past(s_q.loss) == 32'(LOSS_CYCLES - 1))
    else $error("link dropped before timer");

  iso_cov: cover property (iso ##1 reg_wr);
  loop_cov: cover property (loop && tx_act ##1 rx_dv);
  pass_cov: cover property (s_q.bst == ST_RUN ##[1:40] s_q.pass);
  col_cov: cover property (col_raw ##1 col);
endmodule : phy_led_duplex_isolate_self_test

// file: test/mac_model.sv
// Behavioural MAC transmit side feeding the phy under test
module mac_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bench commands
  input wire logic go,
  input wire logic [3:0] nibble,
  // MII transmit pins
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////
  // Data churns outside a frame, so no stale nibble can pass as valid
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txd <= 4'h0;
      tx_en <= 1'b0;
      tx_er <= 1'b0;
    end else begin
      tx_en <= go;
      tx_er <= 1'b0;
      txd <= go ? nibble : ~txd;
    end
  end
endmodule : mac_model

// file: test/phy_led_duplex_isolate_self_test_test.sv
// Self-checking bench for the indicator and mode block
module phy_led_duplex_isolate_self_test_test
  import phy_led_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short loss timer keeps the run brief
  localparam int LOSS = 20;
  // Rows: spd,full,pdet,sd,carrier,tx | rate,dup,link,col,crs,rx,tx
  localparam logic [12:0] ROWS [6] = '{13'h1A70, 13'h1BF7, 13'h1FDF,
    13'h12D5, 13'h1146, 13'h1F56};
  logic clock, rst_n, reg_wr, reg_rd, go, p;
  logic [4:0] reg_addr, s;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic an_speed100, an_full_duplex, an_parallel_detect, signal_detect;
  logic link_pulse, packet_good10, rx_carrier, line_rx_dv, line_rx_er;
  logic tx_en, tx_er, rx_dv, rx_er, crs, col, mii_oe, line_tx_en;
  logic [3:0] line_rxd, txd, rxd, line_txd, nibble;
  logic line_tx_er, dup_o, rate_o, link_o, col_o, rxa_o, txa_o, ind_oe;
  logic [12:0] r;
  logic [7:0] e;
  int bad_count, checked;
  ////////////////////////////////////////////////////////////////////
  mac_model mac (.clock(clock), .rst_n(rst_n), .go(go),
    .nibble(nibble), .txd(txd), .tx_en(tx_en), .tx_er(tx_er));
  phy_led_duplex_isolate_self_test #(.LOSS_CYCLES(LOSS)) dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .address_strap_inputs(s),
    .indicator_polarity_strap(p), .an_speed100(an_speed100),
    .an_full_duplex(an_full_duplex),
    .an_parallel_detect(an_parallel_detect),
    .signal_detect(signal_detect), .link_pulse(link_pulse),
    .packet_good10(packet_good10), .rx_carrier(rx_carrier),
    .line_rxd(line_rxd), .line_rx_dv(line_rx_dv),
    .line_rx_er(line_rx_er), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
    .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .col(col),
    .mii_oe(mii_oe), .line_txd(line_txd), .line_tx_en(line_tx_en),
    .line_tx_er(line_tx_er), .duplex_indicator_out(dup_o),
    .rate_indicator_out(rate_o), .link_indicator_out(link_o),
    .col_indicator_out(col_o), .rx_activity_indicator(rxa_o),
    .tx_activity_indicator(txa_o), .indicator_oe(ind_oe));
  ////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // Single-cycle register strobes
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Straps held steady across the release edge
  task automatic do_reset(input logic [4:0] a, input logic b);
    @(posedge clock);
    rst_n <= 1'b0;
    s <= a;
    p <= b;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    cyc(3);
  endtask : do_reset
  task automatic results;
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // Watchdog well past the expected run
  initial begin
    #100000;
    bad_count++;
    results;
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, go, reg_addr, reg_wdata, nibble} = '0;
    {an_speed100, an_full_duplex, an_parallel_detect} = '0;
    {signal_detect, link_pulse, packet_good10, rx_carrier} = '0;
    {line_rxd, line_rx_dv, line_rx_er} = '0;
    {s, p} = {5'h03, 1'b1};
    do_reset(5'h03, 1'b1);
    rd(PHY_CONTROL_IDX);
    chk(d & 16'h011F, 16'h0003);
    rd(5'h05);
    chk(d, 16'h0000);
    // Indicator and carrier table
    foreach (ROWS[i]) begin
      r = ROWS[i];
      @(posedge clock);
      {an_speed100, an_full_duplex, an_parallel_detect} <= r[12:10];
      {signal_detect, rx_carrier, go} <= r[9:7];
      cyc(5);
      e = {r[6], r[5] ^ (p & s[0]), r[4] ^ s[2], r[3] ^ s[1], r[2],
        r[1] ^ s[4], r[0] ^ s[3], r[3]};
      chk(16'({rate_o, dup_o, link_o, col_o, crs, rxa_o, txa_o, col}),
        16'(e));
    end
    // Ten megabit link qualification and loss
    @(posedge clock);
    {an_speed100, an_full_duplex, go, rx_carrier} <= '0;
    cyc(30);
    repeat (6) begin
      @(posedge clock) link_pulse <= 1'b1;
      @(posedge clock) link_pulse <= 1'b0;
    end
    cyc(3);
    chk(16'(link_o), 16'h0000);
    @(posedge clock) link_pulse <= 1'b1;
    @(posedge clock) link_pulse <= 1'b0;
    cyc(3);
    chk(16'(link_o), 16'h0001);
    chk(16'(rate_o), 16'h0000);
    rd(PHY_STATUS_IDX);
    chk(d & 16'h000F, 16'h0003);
    cyc(LOSS - 10);
    chk(16'(link_o), 16'h0001);
    cyc(12);
    chk(16'(link_o), 16'h0000);
    @(posedge clock) packet_good10 <= 1'b1;
    @(posedge clock) packet_good10 <= 1'b0;
    cyc(3);
    chk(16'(link_o), 16'h0001);
    @(posedge clock) {go, rx_carrier} <= 2'b11;
    cyc(4);
    chk(16'({col_o, col, crs}), 16'h0003);
    @(posedge clock) {go, rx_carrier} <= 2'b00;
    // Loopback with negotiation off
    wr(BASIC_CONTROL_IDX, 16'h4000);
    rd(PHY_STATUS_IDX);
    chk(d & 16'h000E, 16'h000A);
    @(posedge clock) {go, nibble} <= {1'b1, 4'hA};
    cyc(3);
    chk(16'({rx_er, rx_dv, rxd}), 16'h001A);
    wr(BASIC_CONTROL_IDX, 16'h6000);
    cyc(3);
    chk(16'({rx_dv, line_tx_en, line_txd}), 16'h002A);
    @(posedge clock) go <= 1'b0;
    // Self-test, short then long pattern
    wr(PHY_CONTROL_IDX, 16'h0200);
    cyc(40);
    rd(PHY_CONTROL_IDX);
    chk(d & 16'h0700, 16'h0300);
    wr(PHY_CONTROL_IDX, 16'h0000);
    rd(PHY_CONTROL_IDX);
    chk(d & 16'h0700, 16'h0100);
    wr(PHY_CONTROL_IDX, 16'h0600);
    cyc(60);
    rd(PHY_CONTROL_IDX);
    chk(d & 16'h0700, 16'h0700);
    // Miscompare from the line latches fail
    wr(PHY_CONTROL_IDX, 16'h0200);
    wr(BASIC_CONTROL_IDX, 16'h0000);
    @(posedge clock) line_rx_dv <= 1'b1;
    repeat (30) @(posedge clock) line_rxd <= ~line_rxd;
    line_rx_dv <= 1'b0;
    wr(BASIC_CONTROL_IDX, 16'h6000);
    cyc(40);
    rd(PHY_CONTROL_IDX);
    chk(d & 16'h0100, 16'h0000);
    wr(PHY_CONTROL_IDX, 16'h0200);
    cyc(40);
    rd(PHY_CONTROL_IDX);
    chk(d & 16'h0100, 16'h0100);
    // Isolate by control bit; address zero by write does not isolate
    wr(PHY_CONTROL_IDX, 16'h0000);
    cyc(1);
    chk(16'(mii_oe), 16'h0001);
    wr(BASIC_CONTROL_IDX, 16'h0400);
    @(posedge clock) go <= 1'b1;
    cyc(3);
    chk(16'({mii_oe, line_tx_en, line_txd, line_tx_er}),
      16'h0000);
    @(posedge clock) go <= 1'b0;
    rd(BASIC_CONTROL_IDX);
    chk(d, 16'h0400);
    wr(BASIC_CONTROL_IDX, 16'h0000);
    cyc(2);
    chk(16'(mii_oe), 16'h0001);
    // Polarity strap low, then address zero strapped
    @(posedge clock)
      {an_speed100, an_full_duplex, an_parallel_detect} <= 3'b110;
    do_reset(5'h01, 1'b0);
    chk(16'(dup_o), 16'h0001);
    do_reset(5'h00, 1'b1);
    chk(16'({ind_oe, mii_oe}), 16'h0002);
    results;
  end
endmodule : phy_led_duplex_isolate_self_test_test
